// ==== logic/psdl_top.sv ====
// PHY strap default loader: latches straps, presets PHY register bits.
`timescale 1ns/1ns
`include "psdl_consts.svh"
module psdl_top #(
  parameter int DATA_W = 16,
  parameter int ADDR_W = 8
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic phy_a_low_power_strap,
  input wire logic phy_b_auto_crossover_strap,
  input wire logic phy_b_manual_crossover_strap,
  input wire logic phy_b_negotiation_strap,
  input wire logic phy_b_speed_strap,
  input wire logic phy_b_duplex_strap,
  input wire logic phy_a_fiber_mode,
  input wire logic phy_b_fiber_mode,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [DATA_W-1:0] reg_rdata,
  output logic load_done,
  output logic phy_a_low_power_enable_bit,
  output logic phy_a_cap_100tx_low_power,
  output logic phy_a_adv_100tx_low_power,
  output logic phy_b_negotiation_enable_bit,
  output logic phy_b_speed_select_low_bit,
  output logic phy_b_duplex_mode_bit,
  output logic phy_b_adv_10_full,
  output logic phy_b_adv_10_half,
  output logic [2:0] phy_b_mode,
  output logic phy_b_auto_crossover,
  output logic phy_b_crossed
);

  // ****************************************************************
  // Decode helpers
  // ****************************************************************
  function automatic logic psdl_mapped(input logic [ADDR_W-1:0] a);
    psdl_mapped = (a < ADDR_W'(`PSDL_NUM_REGS));
  endfunction

  function automatic logic [DATA_W-1:0] psdl_wmask(input logic [2:0] idx);
    logic [DATA_W-1:0] m;
    m = '0;
    case (idx)
      `PSDL_OFS_PHYA_PDX: m[`PSDL_B_LP_EN] = 1'h1;
      `PSDL_OFS_PHYA_CAP, `PSDL_OFS_PHYA_ADV: m[`PSDL_B_LP_100TX] = 1'h1;
      `PSDL_OFS_PHYB_SPC: m[`PSDL_B_SW_MDIX:`PSDL_B_SRC_SEL] = 3'h7;
      `PSDL_OFS_PHYB_BASIC: begin
        m[`PSDL_B_AN_EN] = 1'h1;
        m[`PSDL_B_SPEED_LSB] = 1'h1;
        m[`PSDL_B_DUPLEX] = 1'h1;
      end
      `PSDL_OFS_PHYB_ADV: m[`PSDL_B_ADV_10FD:`PSDL_B_ADV_10HD] = 2'h3;
      `PSDL_OFS_PHYB_MODES: m[`PSDL_B_MODE_HI:`PSDL_B_MODE_LO] = 3'h7;
      default: m = '0;
    endcase
    psdl_wmask = m;
  endfunction

  // Preset value of one register from a strap vector
  function automatic logic [DATA_W-1:0] psdl_default(
    input logic [2:0] idx,
    input logic [`PSDL_STRAP_W-1:0] s
  );
    logic lp, an, spd, dup;
    logic [DATA_W-1:0] v;
    lp = s[`PSDL_S_FIB_A] ? `PSDL_FIBER_LP : s[`PSDL_S_LP_A];
    an = s[`PSDL_S_FIB_B] ? `PSDL_FIBER_AN : s[`PSDL_S_AN];
    spd = s[`PSDL_S_FIB_B] ? `PSDL_FIBER_SPD : s[`PSDL_S_SPD];
    dup = s[`PSDL_S_DUP];
    v = '0;
    case (idx)
      `PSDL_OFS_PHYA_PDX: v[`PSDL_B_LP_EN] = lp;
      `PSDL_OFS_PHYA_CAP: v[`PSDL_B_LP_100TX] = lp;
      `PSDL_OFS_PHYA_ADV: v[`PSDL_B_LP_100TX] = lp;
      `PSDL_OFS_HWCFG: begin
        v[`PSDL_B_AUTO_STATE] = s[`PSDL_S_AUTO];
        v[`PSDL_B_MAN_STATE] = s[`PSDL_S_MAN];
        v[`PSDL_B_FIB_A] = s[`PSDL_S_FIB_A];
        v[`PSDL_B_FIB_B] = s[`PSDL_S_FIB_B];
      end
      `PSDL_OFS_PHYB_BASIC: begin
        v[`PSDL_B_AN_EN] = an;
        v[`PSDL_B_SPEED_LSB] = spd;
        v[`PSDL_B_DUPLEX] = dup;
      end
      `PSDL_OFS_PHYB_ADV: begin
        // Fixed 100 Mb/s without negotiation offers no 10 Mb/s modes
        v[`PSDL_B_ADV_10HD] = an | ~spd;
        v[`PSDL_B_ADV_10FD] = dup & (an | ~spd);
      end
      `PSDL_OFS_PHYB_MODES: v[`PSDL_B_MODE_HI:`PSDL_B_MODE_LO] =
        an ? `PSDL_MODE_ALL_AN : {1'h0, spd, dup};
      default: v = '0;
    endcase
    psdl_default = v;
  endfunction

  // ****************************************************************
  // Strap capture
  // ****************************************************************
  logic [`PSDL_STRAP_W-1:0] strap_sync;
  psdl_strap_sync #(.WIDTH(`PSDL_STRAP_W)) u_sync (
    .clk(clk),
    .rst_b(rst_b),
    .pin_in({phy_b_fiber_mode, phy_a_fiber_mode, phy_b_duplex_strap,
      phy_b_speed_strap, phy_b_negotiation_strap,
      phy_b_manual_crossover_strap, phy_b_auto_crossover_strap,
      phy_a_low_power_strap}),
    .sync_out(strap_sync)
  );

  // ****************************************************************
  // Load sequencer
  // ****************************************************************
  psdl_pkg::psdl_state_t state;
  psdl_pkg::psdl_state_t next_state;
  logic [1:0] wait_cnt;
  logic [1:0] next_wait_cnt;
  // Waits for the synchroniser to fill, loads once, then runs
  always_comb begin
    next_state = state;
    next_wait_cnt = wait_cnt;
    case (state)
      psdl_pkg::ST_WAIT: begin
        if (wait_cnt == `PSDL_SYNC_WAIT) begin
          next_state = psdl_pkg::ST_LOAD;
        end else begin
          next_wait_cnt = wait_cnt + 2'h1;
        end
      end
      psdl_pkg::ST_LOAD: next_state = psdl_pkg::ST_RUN;
      psdl_pkg::ST_RUN: next_state = psdl_pkg::ST_RUN;
      default: next_state = psdl_pkg::ST_WAIT;
    endcase
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state <= psdl_pkg::ST_WAIT;
      wait_cnt <= 2'h0;
    end else begin
      state <= next_state;
      wait_cnt <= next_wait_cnt;
    end
  end

  // ****************************************************************
  // Register file
  // ****************************************************************
  logic [DATA_W-1:0] regs [0:`PSDL_NUM_REGS-1];
  logic [DATA_W-1:0] next_regs [0:`PSDL_NUM_REGS-1];
  logic wr_hit;
  // Writes before the load would be overwritten, so they are dropped
  assign wr_hit = reg_wr && psdl_mapped(reg_addr) &&
    (state == psdl_pkg::ST_RUN);

  always_comb begin
    for (int i = 0; i < `PSDL_NUM_REGS; i++) begin
      next_regs[i] = regs[i];
      if (state == psdl_pkg::ST_LOAD) begin
        next_regs[i] = psdl_default(3'(i), strap_sync);
      end else if (wr_hit && (reg_addr[2:0] == 3'(i))) begin
        next_regs[i] = (regs[i] & ~psdl_wmask(3'(i))) |
          (reg_wdata & psdl_wmask(3'(i)));
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      for (int i = 0; i < `PSDL_NUM_REGS; i++) begin
        regs[i] <= psdl_default(3'(i), `PSDL_STRAP_RESET);
      end
    end else begin
      for (int i = 0; i < `PSDL_NUM_REGS; i++) begin
        regs[i] <= next_regs[i];
      end
    end
  end

  // ****************************************************************
  // Crossover selection
  // ****************************************************************
  logic next_auto;
  logic next_cross;
  logic src_sw;
  logic lat_auto;
  logic lat_man;
  logic lat_fib_b;
  assign src_sw = regs[`PSDL_OFS_PHYB_SPC][`PSDL_B_SRC_SEL];
  assign lat_auto = regs[`PSDL_OFS_HWCFG][`PSDL_B_AUTO_STATE];
  assign lat_man = regs[`PSDL_OFS_HWCFG][`PSDL_B_MAN_STATE];
  assign lat_fib_b = regs[`PSDL_OFS_HWCFG][`PSDL_B_FIB_B];

  always_comb begin
    if (lat_fib_b) begin
      next_auto = `PSDL_FIBER_AUTO;
      next_cross = `PSDL_FIBER_MAN;
    end else if (src_sw) begin
      next_auto = regs[`PSDL_OFS_PHYB_SPC][`PSDL_B_SW_AUTO];
      next_cross = ~next_auto & regs[`PSDL_OFS_PHYB_SPC][`PSDL_B_SW_MDIX];
    end else begin
      next_auto = lat_auto;
      next_cross = ~lat_auto & lat_man;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      phy_b_auto_crossover <= 1'h0;
      phy_b_crossed <= 1'h0;
    end else begin
      phy_b_auto_crossover <= next_auto;
      phy_b_crossed <= next_cross;
    end
  end

  // ****************************************************************
  // Read port
  // ****************************************************************
  logic [DATA_W-1:0] next_rdata;
  // Data only in the cycle after the strobe; unmapped reads give zero
  always_comb begin
    next_rdata = '0;
    if (reg_rd && psdl_mapped(reg_addr)) begin
      next_rdata = regs[reg_addr[2:0]];
      if (reg_addr[2:0] == `PSDL_OFS_PHYB_SPC) begin
        next_rdata[`PSDL_B_EFF_AUTO] = phy_b_auto_crossover;
        next_rdata[`PSDL_B_EFF_MDIX] = phy_b_crossed;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      reg_rdata <= '0;
    end else begin
      reg_rdata <= next_rdata;
    end
  end

  // ****************************************************************
  // Outputs to the PHYs
  // ****************************************************************
  assign load_done = (state == psdl_pkg::ST_RUN);
  assign phy_a_low_power_enable_bit =
    regs[`PSDL_OFS_PHYA_PDX][`PSDL_B_LP_EN];
  assign phy_a_cap_100tx_low_power =
    regs[`PSDL_OFS_PHYA_CAP][`PSDL_B_LP_100TX];
  assign phy_a_adv_100tx_low_power =
    regs[`PSDL_OFS_PHYA_ADV][`PSDL_B_LP_100TX];
  assign phy_b_negotiation_enable_bit =
    regs[`PSDL_OFS_PHYB_BASIC][`PSDL_B_AN_EN];
  assign phy_b_speed_select_low_bit =
    regs[`PSDL_OFS_PHYB_BASIC][`PSDL_B_SPEED_LSB];
  assign phy_b_duplex_mode_bit = regs[`PSDL_OFS_PHYB_BASIC][`PSDL_B_DUPLEX];
  assign phy_b_adv_10_full = regs[`PSDL_OFS_PHYB_ADV][`PSDL_B_ADV_10FD];
  assign phy_b_adv_10_half = regs[`PSDL_OFS_PHYB_ADV][`PSDL_B_ADV_10HD];
  assign phy_b_mode =
    regs[`PSDL_OFS_PHYB_MODES][`PSDL_B_MODE_HI:`PSDL_B_MODE_LO];

  // ****************************************************************
  // Checks
  // ****************************************************************
  logic st_load;
  logic st_run;
  logic eff_lp;
  logic eff_an;
  logic eff_spd;
  assign st_load = (state == psdl_pkg::ST_LOAD);
  assign st_run = (state == psdl_pkg::ST_RUN);
  assign eff_lp = strap_sync[`PSDL_S_FIB_A] ? `PSDL_FIBER_LP :
    strap_sync[`PSDL_S_LP_A];
  assign eff_an = strap_sync[`PSDL_S_FIB_B] ? `PSDL_FIBER_AN :
    strap_sync[`PSDL_S_AN];
  assign eff_spd = strap_sync[`PSDL_S_FIB_B] ? `PSDL_FIBER_SPD :
    strap_sync[`PSDL_S_SPD];

  chk_lp_enable_load: assert property (
    @(posedge clk) disable iff (!rst_b)
    st_load |=> phy_a_low_power_enable_bit == $past(eff_lp))
    else $error("low-power enable not preset from strap");
  chk_lp_cap_adv: assert property (
    @(posedge clk) disable iff (!rst_b)
    st_load |=> (phy_a_cap_100tx_low_power == $past(eff_lp)) &&
      (phy_a_adv_100tx_low_power == $past(eff_lp)))
    else $error("100TX low-power bits not preset from strap");
  chk_fiber_ignores_straps: assert property (
    @(posedge clk) disable iff (!rst_b)
    st_load && strap_sync[`PSDL_S_FIB_B] |=>
      !phy_b_negotiation_enable_bit && phy_b_speed_select_low_bit
      ##1 !phy_b_auto_crossover && !phy_b_crossed)
    else $error("fiber PHY took copper straps");
  chk_auto_state_copy: assert property (
    @(posedge clk) disable iff (!rst_b)
    st_load |=> regs[`PSDL_OFS_HWCFG][`PSDL_B_AUTO_STATE] ==
      $past(strap_sync[`PSDL_S_AUTO]))
    else $error("auto-crossover strap state not copied");
  chk_strap_auto_xover: assert property (
    @(posedge clk) disable iff (!rst_b)
    st_run && !src_sw && !lat_fib_b |=>
      phy_b_auto_crossover == $past(lat_auto))
    else $error("auto-crossover not following strap");
  chk_manual_xover: assert property (
    @(posedge clk) disable iff (!rst_b)
    st_run && !src_sw && !lat_fib_b && !lat_auto |=>
      !phy_b_auto_crossover && (phy_b_crossed == $past(lat_man)))
    else $error("manual crossover strap not applied");
  chk_negotiation_load: assert property (
    @(posedge clk) disable iff (!rst_b)
    st_load |=> phy_b_negotiation_enable_bit == $past(eff_an))
    else $error("negotiation enable not preset from strap");
  chk_negotiation_mode: assert property (
    @(posedge clk) disable iff (!rst_b)
    st_load && eff_an |=> (phy_b_mode == `PSDL_MODE_ALL_AN) &&
      phy_b_adv_10_half)
    else $error("negotiation strap did not shape mode");
  chk_speed_fixed: assert property (
    @(posedge clk) disable iff (!rst_b)
    st_load && !eff_an |=> (phy_b_speed_select_low_bit == $past(eff_spd))
      && (phy_b_mode[1] == $past(eff_spd)) &&
      (phy_b_adv_10_half == !$past(eff_spd)))
    else $error("speed strap did not shape defaults");
  chk_duplex_load: assert property (
    @(posedge clk) disable iff (!rst_b)
    st_load |=> phy_b_duplex_mode_bit == $past(strap_sync[`PSDL_S_DUP]))
    else $error("duplex strap not preset");
  chk_write_overrides: assert property (
    @(posedge clk) disable iff (!rst_b)
    st_run && reg_wr && (reg_addr == ADDR_W'(`PSDL_OFS_PHYB_BASIC)) |=>
      st_run && (phy_b_negotiation_enable_bit ==
      $past(reg_wdata[`PSDL_B_AN_EN])))
    else $error("software write did not win over strap");

endmodule

// ==== logic/psdl_consts.svh ====
// Constants of the PHY strap default loader: offsets, bits, defaults.
// Notes on behaviour
// - PHY A low-power strap presets enable bit
// - Same strap presets 100TX capability and advertisement
// - Fiber mode PHY ignores its mode straps except the duplex strap
// - Auto-crossover strap copied into configuration status
// - Strap source selected: straps decide crossover
// - Auto strap low: manual strap picks MDI/MDIX
// - Negotiation strap presets negotiation enable bit
// - Negotiation strap shapes adverts, mode
// - Speed strap shapes speed, adverts, mode
// - Duplex strap shapes duplex, advert, mode
`ifndef PSDL_CONSTS_SVH
`define PSDL_CONSTS_SVH

// ****************************************************************
// Register indices
// ****************************************************************
`define PSDL_NUM_REGS 8
`define PSDL_OFS_PHYA_PDX 3'h0
`define PSDL_OFS_PHYA_CAP 3'h1
`define PSDL_OFS_PHYA_ADV 3'h2
`define PSDL_OFS_HWCFG 3'h3
`define PSDL_OFS_PHYB_SPC 3'h4
`define PSDL_OFS_PHYB_BASIC 3'h5
`define PSDL_OFS_PHYB_ADV 3'h6
`define PSDL_OFS_PHYB_MODES 3'h7

// ****************************************************************
// Field positions
// ****************************************************************
`define PSDL_B_LP_EN 2
`define PSDL_B_LP_100TX 1
`define PSDL_B_AUTO_STATE 0
`define PSDL_B_MAN_STATE 1
`define PSDL_B_FIB_A 2
`define PSDL_B_FIB_B 3
`define PSDL_B_SRC_SEL 0
`define PSDL_B_SW_AUTO 1
`define PSDL_B_SW_MDIX 2
`define PSDL_B_EFF_AUTO 4
`define PSDL_B_EFF_MDIX 5
`define PSDL_B_AN_EN 12
`define PSDL_B_SPEED_LSB 13
`define PSDL_B_DUPLEX 8
`define PSDL_B_ADV_10HD 5
`define PSDL_B_ADV_10FD 6
`define PSDL_B_MODE_LO 5
`define PSDL_B_MODE_HI 7
`define PSDL_MODE_ALL_AN 3'h7

// ****************************************************************
// Strap vector bit order and values
// ****************************************************************
`define PSDL_S_LP_A 0
`define PSDL_S_AUTO 1
`define PSDL_S_MAN 2
`define PSDL_S_AN 3
`define PSDL_S_SPD 4
`define PSDL_S_DUP 5
`define PSDL_S_FIB_A 6
`define PSDL_S_FIB_B 7
`define PSDL_STRAP_W 8
`define PSDL_STRAP_RESET 8'h3A
`define PSDL_FIBER_LP 1'h0
`define PSDL_FIBER_AUTO 1'h0
`define PSDL_FIBER_MAN 1'h0
`define PSDL_FIBER_AN 1'h0
`define PSDL_FIBER_SPD 1'h1

// ****************************************************************
// Timing
// ****************************************************************
`define PSDL_SYNC_WAIT 2'h2

`endif

// ==== logic/psdl_pkg.sv ====
// Types of the PHY strap default loader.
package psdl_pkg;
  typedef enum logic [2:0] {
    ST_WAIT = 3'b001,
    ST_LOAD = 3'b010,
    ST_RUN = 3'b100
  } psdl_state_t;
endpackage

// ==== logic/psdl_strap_sync.sv ====
// Two-stage synchroniser for the strap pins.
`timescale 1ns/1ns
module psdl_strap_sync #(
  parameter int WIDTH = 8
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [WIDTH-1:0] pin_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      meta <= '0;
      sync_out <= '0;
    end else begin
      meta <= pin_in;
      sync_out <= meta;
    end
  end
endmodule

// ==== bench/psdl_strap_pulls.sv ====
// Pull resistors on the strap pins, which the bench may overdrive.
`timescale 1ns/1ns
module psdl_strap_pulls #(
  parameter logic LP_PULL = 1'h0
) (
  input wire logic [7:0] drive_en,
  input wire logic [7:0] drive_val,
  output logic [7:0] strap_line
);
  logic [7:0] pull;
  // Low-power pin has no fixed pull level, so it is a parameter
  assign pull[0] = LP_PULL;
  assign pull[1] = 1'h1;
  assign pull[2] = 1'h0;
  assign pull[3] = 1'h1;
  assign pull[4] = 1'h1;
  assign pull[5] = 1'h1;
  assign pull[7:6] = 2'h0;
  // An undriven line settles to its pull level
  assign strap_line = (drive_en & drive_val) | (~drive_en & pull);
endmodule

// ==== bench/test_phy_strap_default_loader.sv ====
// Self-checking bench of the PHY strap default loader.
`timescale 1ns/1ns
`define CHK(nm, ex, got) begin \
  check_count++; \
  if ((got) !== (ex)) begin \
    err_total++; \
    $display("unexpected %s expected %h seen %h", nm, ex, got); \
  end \
end
module test_phy_strap_default_loader;
  logic clk = 1'h0;
  logic rst_b = 1'h0;
  logic [7:0] drive_en = 8'h00;
  logic [7:0] drive_val = 8'h00;
  logic [7:0] strap_line;
  logic [7:0] reg_addr = 8'h00;
  logic [15:0] reg_wdata = 16'h0000;
  logic reg_wr = 1'h0;
  logic reg_rd = 1'h0;
  logic [15:0] reg_rdata;
  logic load_done, lp_en, lp_cap, lp_adv, an_en, spd, dup, f10, h10;
  logic auto_x, crossed;
  logic [2:0] mode;
  logic [15:0] exp_q [$];
  logic [15:0] mask_q [$];
  logic [15:0] e, m;
  logic [7:0] s;
  logic rd_pend = 1'h0;
  int seed = 32'h7E6B932E;
  int err_total = 0;
  int check_count = 0;

  always #4 clk = ~clk;

  psdl_strap_pulls pulls (.drive_en(drive_en), .drive_val(drive_val),
    .strap_line(strap_line));

  psdl_top dut (.clk(clk), .rst_b(rst_b),
    .phy_a_low_power_strap(strap_line[0]),
    .phy_b_auto_crossover_strap(strap_line[1]),
    .phy_b_manual_crossover_strap(strap_line[2]),
    .phy_b_negotiation_strap(strap_line[3]),
    .phy_b_speed_strap(strap_line[4]), .phy_b_duplex_strap(strap_line[5]),
    .phy_a_fiber_mode(strap_line[6]), .phy_b_fiber_mode(strap_line[7]),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .load_done(load_done),
    .phy_a_low_power_enable_bit(lp_en), .phy_a_cap_100tx_low_power(lp_cap),
    .phy_a_adv_100tx_low_power(lp_adv), .phy_b_negotiation_enable_bit(an_en),
    .phy_b_speed_select_low_bit(spd), .phy_b_duplex_mode_bit(dup),
    .phy_b_adv_10_full(f10), .phy_b_adv_10_half(h10), .phy_b_mode(mode),
    .phy_b_auto_crossover(auto_x), .phy_b_crossed(crossed));

  // ****************************************************************
  // Expected register images from a strap vector
  // ****************************************************************
  function automatic logic [15:0] regval(input logic [7:0] v,
                                         input logic [2:0] idx);
    logic lp, an, sp, hd, fb;
    logic [15:0] r;
    fb = v[7];
    lp = v[0] & ~v[6];
    an = v[3] & ~fb;
    sp = v[4] | fb;
    hd = an | ~sp;
    r = 16'h0000;
    case (idx)
      3'h0: r[2] = lp;
      3'h1, 3'h2: r[1] = lp;
      3'h3: r[3:0] = {fb, v[6], v[2], v[1]};
      3'h4: r[5:4] = {~v[1] & v[2] & ~fb, v[1] & ~fb};
      3'h5: r = {2'h0, sp, an, 3'h0, v[5], 8'h00};
      3'h6: r[6:5] = {v[5] & hd, hd};
      default: r[7:5] = an ? 3'h7 : {1'h0, sp, v[5]};
    endcase
    return r;
  endfunction

  // ****************************************************************
  // Register bus and checking tasks
  // ****************************************************************
  task wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'h1;
    @(posedge clk);
    reg_wr <= 1'h0;
  endtask

  task rd(input logic [7:0] a, input logic [15:0] ex, input logic [15:0] mk);
    @(posedge clk);
    exp_q.push_back(ex);
    mask_q.push_back(mk);
    reg_addr <= a;
    reg_rd <= 1'h1;
    @(posedge clk);
    reg_rd <= 1'h0;
  endtask

  // Read data stand one cycle only, so look mid-cycle after the take
  always @(negedge clk) begin
    if (rd_pend) begin
      e = exp_q.pop_front();
      m = mask_q.pop_front();
      `CHK("reg_rdata", e & m, reg_rdata & m)
    end else if (rst_b === 1'h1) begin
      `CHK("idle_rdata", 16'h0000, reg_rdata)
    end
    rd_pend = reg_rd;
  end

  task do_reset(input logic [7:0] en, input logic [7:0] val);
    int n;
    @(posedge clk);
    rst_b <= 1'h0;
    drive_en <= en;
    drive_val <= val;
    repeat (2) @(posedge clk);
    rst_b <= 1'h1;
    // Early write must lose against the strap load
    wr(8'h05, 16'h0000);
    n = 0;
    while (load_done !== 1'h1 && n < 20) begin
      @(posedge clk);
      n++;
    end
    `CHK("load_done", 1'h1, load_done)
    repeat (2) @(posedge clk);
  endtask

  task chk_ports(input logic [7:0] v);
    logic [15:0] x [8];
    for (int k = 0; k < 8; k++) begin
      x[k] = regval(v, k[2:0]);
    end
    @(negedge clk);
    `CHK("lp_en", x[0][2], lp_en)
    `CHK("lp_cap", x[1][1], lp_cap)
    `CHK("lp_adv", x[2][1], lp_adv)
    `CHK("an_en", x[5][12], an_en)
    `CHK("speed", x[5][13], spd)
    `CHK("duplex", x[5][8], dup)
    `CHK("adv10fd", x[6][6], f10)
    `CHK("adv10hd", x[6][5], h10)
    `CHK("mode", x[7][7:5], mode)
    `CHK("auto_x", x[4][4], auto_x)
    `CHK("crossed", x[4][5], crossed)
  endtask

  task check_regs(input logic [7:0] v);
    for (int k = 0; k < 8; k++) begin
      // Manual strap image under fiber and software bits left open
      rd(k[7:0], regval(v, k[2:0]),
        k == 4 ? 16'hFFF8 : (k == 3 && v[7]) ? 16'hFFFD : 16'hFFFF);
    end
    rd(8'h08, 16'h0000, 16'hFFFF);
    rd(8'hFF, 16'h0000, 16'hFFFF);
  endtask

  task end_of_test;
    $display("checks %0d errors %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  initial begin
    #(8 * 5000);
    err_total++;
    end_of_test;
  end

  initial begin
    do_reset(8'h00, 8'h00);
    chk_ports(8'h3A);
    check_regs(8'h3A);
    for (int i = 0; i < 16; i++) begin
      s = 8'($random(seed));
      s[7:6] = i[1:0];
      s[1] = i[2];
      s[2] = i[3];
      do_reset(8'hFF, s);
      chk_ports(s);
      check_regs(s);
    end
    // Late strap changes must not reach the loaded bits
    s = 8'h3A;
    do_reset(8'hFF, s);
    drive_val <= ~s;
    repeat (4) @(posedge clk);
    chk_ports(s);
    wr(8'h05, 16'h0000);
    @(negedge clk);
    `CHK("an_sw", 1'h0, an_en)
    wr(8'h04, 16'h0005);
    repeat (2) @(negedge clk);
    `CHK("crossed_sw", 1'h1, crossed)
    `CHK("auto_sw", 1'h0, auto_x)
    wr(8'h03, 16'hFFFF);
    rd(8'h03, regval(s, 3'h3), 16'hFFFF);
    rd(8'h05, 16'h0000, 16'hFFFF);
    rd(8'h04, 16'h0020, 16'hFFF8);
    // Software auto source, then a write past the map that must not alias
    wr(8'h04, 16'h0003);
    wr(8'h08, 16'hFFFF);
    repeat (2) @(negedge clk);
    `CHK("auto_sw1", 1'h1, auto_x)
    `CHK("crossed_sw1", 1'h0, crossed)
    `CHK("lp_unmapped", 1'h0, lp_en)
    wr(8'h00, 16'hFFFF);
    wr(8'h07, 16'h0000);
    @(negedge clk);
    `CHK("lp_sw", 1'h1, lp_en)
    `CHK("mode_sw", 3'h0, mode)
    repeat (3) @(posedge clk);
    end_of_test;
  end
endmodule
